// File: hdl/asm_pkg.sv
// Constants and types shared by the audio slot channel map design
package asm_pkg;

    // ------------------------------------------------------------------
    // Register map (page 0, byte addresses as printed)
    // ------------------------------------------------------------------
    localparam logic [7:0] CHAN5_SLOT_CONFIG_ADDR = 8'h0F;
    localparam logic [7:0] CHAN6_SLOT_CONFIG_ADDR = 8'h10;
    localparam logic [7:0] CHAN7_SLOT_CONFIG_ADDR = 8'h11;
    localparam logic [7:0] SLOT_MAP_STATUS_ADDR   = 8'h20;

    // ------------------------------------------------------------------
    // Reset values of the stored fields (line select, slot index)
    // ------------------------------------------------------------------
    localparam logic [6:0] CHAN5_SLOT_CONFIG_RESET = 7'h04;
    localparam logic [6:0] CHAN6_SLOT_CONFIG_RESET = 7'h05;
    localparam logic [6:0] CHAN7_SLOT_CONFIG_RESET = 7'h06;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int LINE_SELECT_BIT = 6;
    localparam int SLOT_HALF_BIT   = 5;
    localparam int STATUS_UNDERRUN = 0;
    localparam int STATUS_EMPTY    = 1;
    localparam int STATUS_SECOND   = 2;

    // ------------------------------------------------------------------
    // Stream shape and counts
    // ------------------------------------------------------------------
    localparam int         SAMPLE_WIDTH = 32;
    localparam int         CHANNELS     = 3;
    localparam int         FIFO_DEPTH   = 8;
    localparam int         SYNC_STAGES  = 3;
    localparam logic [10:0] POS_RESET   = 11'h000;
    localparam logic [10:0] POS_LAST    = 11'h7FF;

    // Serial formats selected outside this block
    typedef enum logic [1:0]
    {
        ASM_FMT_TDM  = 2'h0,
        ASM_FMT_I2S  = 2'h1,
        ASM_FMT_LEFT = 2'h2,
        ASM_FMT_RSVD = 2'h3
    } asm_format_type;

    // Where the serializer stands within a frame
    typedef enum logic [1:0]
    {
        ASM_PH_IDLE,
        ASM_PH_FIRST,
        ASM_PH_SECOND
    } asm_phase_type;

endpackage

// File: hdl/asm_fifo.sv
// Flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps

module asm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_in,       // System clock
    input  wire logic             rst_n_in,     // Synchronous reset, low
    input  wire logic [WIDTH-1:0] in_data_in,   // Write data
    input  wire logic             in_valid_in,  // Write request
    output logic                  in_ready_out, // Room for a word
    output logic [WIDTH-1:0]      out_data_out, // Head word
    output logic                  out_valid_out,// Head word present
    input  wire logic             out_ready_in  // Head word taken
);

    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
    localparam logic [PW-1:0] LAST_PTR   = PW'(DEPTH - 1);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wr_ptr;
        logic [PW-1:0]               rd_ptr;
        logic [CW-1:0]               count;
        logic                        not_full;
        logic                        not_empty;
    } asm_fifo_state_type;

    asm_fifo_state_type q;
    asm_fifo_state_type d;

    // Pointer step with wrap, so any depth works
    function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
        step = (p == LAST_PTR) ? '0 : p + 1'b1;
    endfunction

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // Flags are registered so in ready and out valid both come straight from flops
    always_comb
    begin
        logic push;
        logic pop;
        push = in_valid_in && q.not_full;
        pop  = out_ready_in && q.not_empty;
        d = q;
        if (push)
        begin
            d.mem[q.wr_ptr] = in_data_in;
            d.wr_ptr = step(q.wr_ptr);
        end
        if (pop)
        begin
            d.rd_ptr = step(q.rd_ptr);
        end
        if (push && !pop)
        begin
            d.count = q.count + 1'b1;
        end
        else if (pop && !push)
        begin
            d.count = q.count - 1'b1;
        end
        d.not_full  = (d.count != FULL_COUNT);
        d.not_empty = (d.count != '0);
    end

    // Registers
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            q <= '0;
            q.not_full <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    assign in_ready_out  = q.not_full;
    assign out_valid_out = q.not_empty;
    assign out_data_out  = q.mem[q.rd_ptr];

endmodule

// File: hdl/asm_slot_map.sv
// Slot and line mapping of serial audio channels 5, 6 and 7
//
// What this block does
// - Line-select bit 0 sends the channel to primary line, 1 to secondary.
// - In TDM the channel fills the slot equal to its six-bit slot field.
// - In two-channel formats field values 0 to 31 are left slots directly.
// - In two-channel formats values 32 to 63 are right slot value minus 32.
// - Channel 6 config register at 0x10, resets to 0x05.
// - Channel 7 config register at 0x11, resets to 0x06.
// - Channel 5 slot field resets to 4.
// - Channel 5 config register at 0x0F, just below channel 6.
`timescale 1ns/1ps

module asm_slot_map (
    input  wire logic        clk_in,              // 40 MHz system clock
    input  wire logic        rst_n_in,            // Synchronous reset, low
    input  wire logic [7:0]  reg_addr_in,         // Register address
    input  wire logic [7:0]  reg_wdata_in,        // Register write data
    input  wire logic        reg_wr_in,           // Write strobe
    input  wire logic        reg_rd_in,           // Read strobe
    output logic      [7:0]  reg_rdata_out,       // Read data, next cycle
    input  wire logic [1:0]  serial_format_in,    // Frame format code
    input  wire logic        bit_clock_in,        // Link bit clock pin
    input  wire logic        frame_sync_in,       // Link frame sync pin
    input  wire logic [95:0] sample_data_in,      // {ch7, ch6, ch5}
    input  wire logic        sample_valid_in,     // Frame of samples offered
    output logic             sample_ready_out,    // FIFO has room
    output logic             primary_serial_out,  // Primary data line
    output logic             primary_oe_out,      // Primary line driven
    output logic             secondary_serial_out,// Secondary data line
    output logic             secondary_oe_out     // Secondary line driven
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [6:0]          cfg5_lo;
        logic [6:0]          cfg6;
        logic [6:0]          cfg7;
        logic [asm_pkg::SYNC_STAGES-1:0] clk_sync;
        logic [asm_pkg::SYNC_STAGES-1:0] fs_sync;
        logic                clk_lvl;
        logic                fs_lvl;
        logic                fs_prev;
        asm_pkg::asm_phase_type phase;
        logic [10:0]         pos;
        logic [asm_pkg::CHANNELS-1:0][asm_pkg::SAMPLE_WIDTH-1:0] smp;
        logic                underrun;
        logic [7:0]          rdata;
        logic                pri_data;
        logic                pri_oe;
        logic                sec_data;
        logic                sec_oe;
    } asm_state_type;

    asm_state_type q;
    asm_state_type d;

    logic [95:0] fifo_data;
    logic        fifo_valid;
    logic        fifo_pop;

    // ------------------------------------------------------------------
    // Sample FIFO: one word holds a whole frame for the three channels
    // ------------------------------------------------------------------
    asm_fifo #(
        .WIDTH (asm_pkg::SAMPLE_WIDTH * asm_pkg::CHANNELS),
        .DEPTH (asm_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_in        (clk_in),
        .rst_n_in      (rst_n_in),
        .in_data_in    (sample_data_in),
        .in_valid_in   (sample_valid_in),
        .in_ready_out  (sample_ready_out),
        .out_data_out  (fifo_data),
        .out_valid_out (fifo_valid),
        .out_ready_in  (fifo_pop)
    );

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Does a channel with this config own the current slot?
    function automatic logic slot_hit(
        input logic [5:0] field,
        input logic       tdm,
        input logic       right,
        input logic [5:0] slot
    );
        if (tdm)
        begin
            slot_hit = (field == slot);
        end
        else
        begin
            // Upper half of the field names the right half of the frame
            slot_hit = (field[asm_pkg::SLOT_HALF_BIT] == right)
                    && (field[4:0] == slot[4:0])
                    && !slot[5];
        end
    endfunction

    // Register read view: bit 7 never stored, so it reads zero
    function automatic logic [7:0] cfg_view(input logic [6:0] cfg);
        cfg_view = {1'b0, cfg};
    endfunction

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        logic                  tdm;
        logic                  rise_start;
        logic                  clk_rise;
        logic                  clk_fall;
        logic                  fs_up;
        logic                  fs_down;
        logic                  start_edge;
        logic                  half_edge;
        logic [5:0]            slot;
        logic [4:0]            bit_sel;
        logic                  pri_hit;
        logic                  sec_hit;
        logic                  pri_bit;
        logic                  sec_bit;
        logic [2:0][6:0]       cfg_a;
        tdm        = 1'b0;
        rise_start = 1'b0;
        clk_rise   = 1'b0;
        clk_fall   = 1'b0;
        fs_up      = 1'b0;
        fs_down    = 1'b0;
        start_edge = 1'b0;
        half_edge  = 1'b0;
        slot       = '0;
        bit_sel    = '0;
        pri_hit    = 1'b0;
        sec_hit    = 1'b0;
        pri_bit    = 1'b0;
        sec_bit    = 1'b0;
        cfg_a      = {q.cfg7, q.cfg6, q.cfg5_lo};
        fifo_pop   = 1'b0;
        d = q;
        d.rdata = '0;

        // Pin synchronisers; only stages two and three are looked at
        d.clk_sync = {q.clk_sync[1:0], bit_clock_in};
        d.fs_sync  = {q.fs_sync[1:0], frame_sync_in};
        if (q.clk_sync[1] == q.clk_sync[2])
        begin
            d.clk_lvl = q.clk_sync[2];
            clk_rise  = q.clk_sync[2] && !q.clk_lvl;
            clk_fall  = !q.clk_sync[2] && q.clk_lvl;
        end
        if (q.fs_sync[1] == q.fs_sync[2])
        begin
            d.fs_lvl = q.fs_sync[2];
        end

        // Register writes; bit 7 of the data is dropped
        if (reg_wr_in)
        begin
            unique case (reg_addr_in)
                asm_pkg::CHAN5_SLOT_CONFIG_ADDR:
                    d.cfg5_lo = reg_wdata_in[6:0];
                asm_pkg::CHAN6_SLOT_CONFIG_ADDR:
                    d.cfg6 = reg_wdata_in[6:0];
                asm_pkg::CHAN7_SLOT_CONFIG_ADDR:
                    d.cfg7 = reg_wdata_in[6:0];
                asm_pkg::SLOT_MAP_STATUS_ADDR:
                    if (reg_wdata_in[asm_pkg::STATUS_UNDERRUN])
                    begin
                        d.underrun = 1'b0;
                    end
                default:
                    d.underrun = d.underrun;
            endcase
        end

        // Register reads; unmapped addresses answer zero
        if (reg_rd_in)
        begin
            unique case (reg_addr_in)
                asm_pkg::CHAN5_SLOT_CONFIG_ADDR:
                    d.rdata = cfg_view(q.cfg5_lo);
                asm_pkg::CHAN6_SLOT_CONFIG_ADDR:
                    d.rdata = cfg_view(q.cfg6);
                asm_pkg::CHAN7_SLOT_CONFIG_ADDR:
                    d.rdata = cfg_view(q.cfg7);
                asm_pkg::SLOT_MAP_STATUS_ADDR:
                begin
                    d.rdata[asm_pkg::STATUS_UNDERRUN] = q.underrun;
                    d.rdata[asm_pkg::STATUS_EMPTY]    = !fifo_valid;
                    d.rdata[asm_pkg::STATUS_SECOND] =
                        (q.phase == asm_pkg::ASM_PH_SECOND);
                end
                default:
                    d.rdata = '0;
            endcase
        end

        // Frame tracking: sync is sampled on bit clock rising edges
        // TDM and left-justified frames open on a sync rise, I2S on a fall
        // Reserved code 3 falls back to I2S framing
        tdm     = (serial_format_in == 2'(asm_pkg::ASM_FMT_TDM));
        rise_start = tdm || (serial_format_in == 2'(asm_pkg::ASM_FMT_LEFT));
        fs_up   = q.fs_lvl && !q.fs_prev;
        fs_down = !q.fs_lvl && q.fs_prev;
        start_edge = rise_start ? fs_up : fs_down;
        half_edge  = rise_start ? fs_down : fs_up;
        if (clk_rise)
        begin
            d.fs_prev = q.fs_lvl;
            if (start_edge)
            begin
                d.phase = asm_pkg::ASM_PH_FIRST;
                d.pos   = asm_pkg::POS_RESET;
                // Missing samples go out as silence, never stale data
                if (fifo_valid)
                begin
                    fifo_pop = 1'b1;
                    d.smp    = fifo_data;
                end
                else
                begin
                    d.smp      = '0;
                    d.underrun = 1'b1;                // Set beats clear
                end
            end
            else if (half_edge && !tdm && q.phase != asm_pkg::ASM_PH_IDLE)
            begin
                d.phase = asm_pkg::ASM_PH_SECOND;
                d.pos   = asm_pkg::POS_RESET;
            end
            else if (q.pos != asm_pkg::POS_LAST)
            begin
                d.pos = q.pos + 1'b1;
            end
        end

        // Data changes on the falling edge so the host samples it stable
        if (clk_fall)
        begin
            slot    = q.pos[10:5];
            bit_sel = ~q.pos[4:0];                    // MSB first
            // Descending loop: the lowest channel wins a shared slot
            for (int c = asm_pkg::CHANNELS - 1; c >= 0; c--)
            begin
                if (slot_hit(cfg_a[c][5:0], tdm,
                             q.phase == asm_pkg::ASM_PH_SECOND, slot)
                    && q.phase != asm_pkg::ASM_PH_IDLE)
                begin
                    if (cfg_a[c][asm_pkg::LINE_SELECT_BIT])
                    begin
                        sec_hit = 1'b1;
                        sec_bit = q.smp[c][bit_sel];
                    end
                    else
                    begin
                        pri_hit = 1'b1;
                        pri_bit = q.smp[c][bit_sel];
                    end
                end
            end
            d.pri_oe   = pri_hit;
            d.pri_data = pri_bit;
            d.sec_oe   = sec_hit;
            d.sec_data = sec_bit;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            q         <= '0;
            q.phase   <= asm_pkg::ASM_PH_IDLE;
            q.cfg5_lo <= asm_pkg::CHAN5_SLOT_CONFIG_RESET;
            q.cfg6    <= asm_pkg::CHAN6_SLOT_CONFIG_RESET;
            q.cfg7    <= asm_pkg::CHAN7_SLOT_CONFIG_RESET;
        end
        else
        begin
            q <= d;
        end
    end

    // Outputs straight from flops
    assign reg_rdata_out        = q.rdata;
    assign primary_serial_out   = q.pri_data;
    assign primary_oe_out       = q.pri_oe;
    assign secondary_serial_out = q.sec_data;
    assign secondary_oe_out     = q.sec_oe;

endmodule

// File: test/asm_slot_map_properties.sv
// Port-level checks of the audio slot channel map
`timescale 1ns/1ps

module asm_slot_map_properties (
    input wire logic       clk_in,               // System clock
    input wire logic       rst_n_in,             // Reset, low
    input wire logic [7:0] reg_addr_in,          // Register address
    input wire logic [7:0] reg_wdata_in,         // Write data
    input wire logic       reg_wr_in,            // Write strobe
    input wire logic       reg_rd_in,            // Read strobe
    input wire logic [7:0] reg_rdata_out,        // Read data
    input wire logic       bit_clock_in,         // Link clock pin
    input wire logic       sample_ready_out,     // FIFO room
    input wire logic       primary_serial_out,   // Primary data
    input wire logic       primary_oe_out,       // Primary driven
    input wire logic       secondary_serial_out, // Secondary data
    input wire logic       secondary_oe_out      // Secondary driven
);
    logic cfg_a;
    logic fresh_q;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    // Address falls on one of the three channel registers
    assign cfg_a = reg_addr_in >= 8'h0F && reg_addr_in <= 8'h11;

    // Registers untouched since reset; any write ends it, to stay safe
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            fresh_q <= 1'b1;
        else if (reg_wr_in)
            fresh_q <= 1'b0;
    end

    a_rdata_after_read:
        assert property (reg_rdata_out != 8'h00 |-> $past(reg_rd_in))
        else $error("read data without a read strobe");
    a_top_bit_zero:
        assert property (reg_rd_in && cfg_a |=> !reg_rdata_out[7])
        else $error("config top bit read as one");
    a_write_read_back:
        assert property ((reg_wr_in && cfg_a) ##2 (reg_rd_in && cfg_a
            && reg_addr_in == $past(reg_addr_in, 2)) |=>
            reg_rdata_out == {1'b0, $past(reg_wdata_in[6:0], 3)})
        else $error("config read back differs from write");
    a_unmapped_zero:
        assert property (reg_rd_in && !cfg_a && reg_addr_in != 8'h20
            |=> reg_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    a_reset_defaults:
        assert property (fresh_q && reg_rd_in && cfg_a
            |=> reg_rdata_out == $past(reg_addr_in) - 8'h0B)
        else $error("config default value wrong");
    a_primary_unowned:
        assert property (!primary_oe_out |-> !primary_serial_out)
        else $error("primary data high while undriven");
    a_secondary_unowned:
        assert property (!secondary_oe_out |-> !secondary_serial_out)
        else $error("secondary data high while undriven");
    a_quiet_link:
        assert property ($stable(bit_clock_in) [*7] |=>
            $stable({primary_serial_out, primary_oe_out,
                     secondary_serial_out, secondary_oe_out}))
        else $error("serial outputs moved without a clock edge");
    a_ready_holds:
        assert property (($stable(bit_clock_in) [*6]) ##0 !sample_ready_out
            |=> !sample_ready_out)
        else $error("ready rose with no frame start");
endmodule

// File: test/asm_link_host.sv
// Host end of the serial link: clock and sync master, data capture
`timescale 1ns/1ps

module asm_link_host (
    output logic       bit_clock_out,  // Link bit clock
    output logic       frame_sync_out, // Link frame sync
    input  wire logic  pri_in,         // Primary data line
    input  wire logic  pri_oe_in,      // Primary line driven
    input  wire logic  sec_in,         // Secondary data line
    input  wire logic  sec_oe_in       // Secondary line driven
);
    logic [259:0] pri_s;
    logic [259:0] poe_s;
    logic [259:0] sec_s;
    logic [259:0] soe_s;

    // Clock stands still low between frames
    initial
    begin
        bit_clock_out = 1'b0;
        frame_sync_out = 1'b0;
    end

    // One frame; two halves of bits each unless TDM. Data is taken at the
    // next falling edge, since the device updates well after each fall
    task automatic frame(input logic [1:0] fmt, input int bits);
        logic lvl;
        int   n;
        lvl = fmt != 2'h0 && fmt != 2'h2;
        n = (fmt == 2'h0) ? bits : 2 * bits;
        #403;
        for (int i = -2; i <= n + 1; i++)
        begin
            // Sync moves after a fall, ahead of the rise that samples it
            if (i < 0 || (i == bits && fmt != 2'h0))
                frame_sync_out = lvl;
            else if (i == 0)
                frame_sync_out = !lvl;
            else if (fmt == 2'h0)
                frame_sync_out = 1'b0;
            #100 bit_clock_out = 1'b1;
            #100 bit_clock_out = 1'b0;
            if (i >= 0)
            begin
                pri_s[i] = pri_in;
                poe_s[i] = pri_oe_in;
                sec_s[i] = sec_in;
                soe_s[i] = sec_oe_in;
            end
        end
    endtask

    // {enables, data} of 32 captured bits, MSB first
    function automatic logic [63:0] slot(input logic sel, input int at);
        for (int b = 0; b < 32; b++)
        begin
            slot[63-b] = sel ? soe_s[at+b] : poe_s[at+b];
            slot[31-b] = sel ? sec_s[at+b] : pri_s[at+b];
        end
    endfunction
endmodule

// File: test/tb.sv
// Self-checking bench for the audio slot channel map
`timescale 1ns/1ps

module tb;
    typedef struct packed
    {
        logic [7:0] addr;
        logic       wr;
        logic [7:0] wdata;
        logic [7:0] rexp;
    } asm_row_type;

    localparam logic [31:0] ON = 32'hFFFF_FFFF;
    localparam logic [31:0] W5 = 32'hC5C5_0005;
    localparam logic [31:0] W6 = 32'hC6C6_0006;
    localparam logic [31:0] W7 = 32'hC7C7_0007;

    logic        clk_in;
    logic        rst_n_in;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic [7:0]  rdata;
    logic [1:0]  fmt;
    logic        bclk;
    logic        fsync;
    logic [95:0] sdata;
    logic        svalid;
    logic        sready;
    logic        pri;
    logic        poe;
    logic        sec;
    logic        soe;
    int          n_mismatch;
    int          compares;
    // Defaults, an unmapped place, and writes, two with the top bit set
    asm_row_type rows [7] = '{'{8'h0F, 1'b0, 8'h00, 8'h04},
        '{8'h10, 1'b0, 8'h00, 8'h05}, '{8'h11, 1'b0, 8'h00, 8'h06},
        '{8'h30, 1'b1, 8'h55, 8'h00}, '{8'h0F, 1'b1, 8'hFF, 8'h7F},
        '{8'h10, 1'b1, 8'hC0, 8'h40}, '{8'h11, 1'b1, 8'h3F, 8'h3F}};

    asm_slot_map dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_rdata_out(rdata), .serial_format_in(fmt),
        .bit_clock_in(bclk), .frame_sync_in(fsync), .sample_data_in(sdata),
        .sample_valid_in(svalid), .sample_ready_out(sready),
        .primary_serial_out(pri), .primary_oe_out(poe),
        .secondary_serial_out(sec), .secondary_oe_out(soe));

    asm_link_host host_u (.bit_clock_out(bclk), .frame_sync_out(fsync),
        .pri_in(pri), .pri_oe_in(poe), .sec_in(sec), .sec_oe_in(soe));

    // 40 MHz system clock
    initial
    begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end

    task automatic check(input string what, input logic [63:0] exp,
                         input logic [63:0] got);
        compares++;
        if (got !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            n_mismatch++;
        end
    endtask

    // An idle cycle follows, so back-to-back writes always retoggle wr
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
        @(posedge clk_in);
    endtask

    // Read data is looked at mid-cycle, the only cycle it stands
    task automatic reg_check(input logic [7:0] a, input logic [7:0] e);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        @(negedge clk_in);
        check($sformatf("reg %h", a), {56'h0, e}, {56'h0, rdata});
        @(posedge clk_in);
    endtask

    task automatic push(input logic [95:0] w);
        sdata <= w;
        svalid <= 1'b1;
        @(posedge clk_in);
        svalid <= 1'b0;
    endtask

    task automatic run(input logic [1:0] f, input int bits);
        fmt <= f;
        @(posedge clk_in);
        host_u.frame(f, bits);
        @(posedge clk_in);
    endtask

    task automatic conclude();
        $display("n_mismatch %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Guard against a hang: counts as a mismatch
    initial
    begin
        #2000000;
        n_mismatch++;
        conclude();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        rst_n_in = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        fmt = 2'h0;
        sdata = 96'h0;
        svalid = 1'b0;
        n_mismatch = 0;
        compares = 0;
        repeat (6) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        foreach (rows[i])
        begin
            if (rows[i].wr)
                reg_write(rows[i].addr, rows[i].wdata);
            reg_check(rows[i].addr, rows[i].rexp);
        end
        // TDM: channels on both lines, slot equals the field
        reg_write(8'h0F, 8'h04);
        reg_write(8'h10, 8'h41);
        reg_write(8'h11, 8'h07);
        push({W7, W6, W5});
        run(2'h0, 256);
        check("tdm ch5", {ON, W5}, host_u.slot(1'b0, 129));
        check("tdm ch6", {ON, W6}, host_u.slot(1'b1, 33));
        check("tdm ch7", {ON, W7}, host_u.slot(1'b0, 225));
        check("tdm free", 64'h0, host_u.slot(1'b0, 1));
        check("tdm sec free", 64'h0, host_u.slot(1'b1, 129));
        // Two-channel formats, the reserved code among them
        reg_write(8'h0F, 8'h01);
        reg_write(8'h10, 8'h20);
        reg_write(8'h11, 8'h61);
        for (int f = 1; f < 4; f++)
        begin
            push({W7, W6, W5 + 32'(f)});
            run(2'(f), 64);
            check("left ch5", {ON, W5 + f}, host_u.slot(1'b0, 33));
            check("right ch6", {ON, W6}, host_u.slot(1'b0, 65));
            check("right ch7", {ON, W7}, host_u.slot(1'b1, 97));
            check("left free", 64'h0, host_u.slot(1'b0, 1));
        end
        // Link stalled: fill until a ninth word is refused
        reg_write(8'h0F, 8'h00);
        svalid <= 1'b1;
        for (int i = 0; i < 9; i++)
        begin
            sdata <= {W7, W6, 32'(i)};
            @(posedge clk_in);
        end
        svalid <= 1'b0;
        @(negedge clk_in);
        check("ready when full", 64'h0, {63'h0, sready});
        @(posedge clk_in);
        reg_check(8'h20, 8'h04); // Last frame ended in its right half
        // Drain one word per frame, oldest first
        for (int i = 0; i < 8; i++)
        begin
            run(2'h0, 64);
            check("drained", {ON, 32'(i)}, host_u.slot(1'b0, 1));
        end
        check("ready drained", 64'h1, {63'h0, sready});
        reg_check(8'h20, 8'h02);
        // A frame with nothing queued marks underrun; writing one clears it
        run(2'h0, 64);
        reg_check(8'h20, 8'h03);
        reg_write(8'h20, 8'h01);
        reg_check(8'h20, 8'h02);
        // Second reset in mid-run brings the defaults back
        rst_n_in <= 1'b0;
        repeat (6) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        reg_check(8'h0F, 8'h04);
        reg_check(8'h10, 8'h05);
        reg_check(8'h11, 8'h06);
        conclude();
    end
endmodule

bind asm_slot_map asm_slot_map_properties chk_u (.clk_in, .rst_n_in,
    .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
    .bit_clock_in, .sample_ready_out, .primary_serial_out, .primary_oe_out,
    .secondary_serial_out, .secondary_oe_out);
